// File: dgp_pin_env.sv
`timescale 1ns/1ps
// ----------------------------------------
// Circuitry outside the port pins
// ----------------------------------------
module dgp_pin_env (
  // Clock
  input  wire logic       pclk,
  // Device drive
  input  wire logic [5:0] pa_out,
  input  wire logic [5:0] pa_oe,
  input  wire logic [7:0] pb_out,
  input  wire logic [7:0] pb_oe,
  input  wire logic [7:0] pb_pull_en,
  // Outside drive
  input  wire logic [5:0] pa_x,
  input  wire logic [5:0] pa_xe,
  input  wire logic [7:0] pb_x,
  input  wire logic [7:0] pb_xe,
  // Resolved levels
  output logic      [5:0] pa_in,
  output logic      [7:0] pb_in
);
  logic tgl_q = 1'b0;

  // Floating lines wander every cycle
  always @(posedge pclk) tgl_q <= ~tgl_q;

  always_comb
  begin
    for (int i = 0; i < 6; i++)
    begin
      if (pa_oe[i])
        pa_in[i] = (i == 4) ? 1'b0 : pa_out[i];
      else if (pa_xe[i])
        pa_in[i] = pa_x[i];
      else
        pa_in[i] = tgl_q;
    end
    for (int i = 0; i < 8; i++)
    begin
      if (pb_oe[i])
        pb_in[i] = pb_out[i];
      else if (pb_xe[i])
        pb_in[i] = pb_x[i];
      else if (pb_pull_en[i])
        pb_in[i] = 1'b1;
      else
        pb_in[i] = tgl_q;
    end
  end
endmodule : dgp_pin_env

// File: dgp_pkg.sv
package dgp_pkg;

  // ----------------------------------------
  // Register indices (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [8:0] IDX_SECOND_PORT_DATA     = 9'h006;
  localparam logic [8:0] IDX_SECOND_PORT_DATA_ALT = 9'h106;
  localparam logic [8:0] IDX_PIN_OPTION_CONFIG    = 9'h081;
  localparam logic [8:0] IDX_PIN_OPTION_ALT       = 9'h181;
  localparam logic [8:0] IDX_SECOND_PORT_DIR      = 9'h086;
  localparam logic [8:0] IDX_SECOND_PORT_DIR_ALT  = 9'h186;
  localparam logic [8:0] IDX_FIRST_PORT_DATA      = 9'h005;
  localparam logic [8:0] IDX_FIRST_PORT_DIR       = 9'h085;
  localparam logic [8:0] IDX_COMPARATOR_CONFIG    = 9'h09c;
  localparam logic [8:0] IDX_ANALOG_PIN_CONFIG    = 9'h09f;
  localparam logic [8:0] IDX_PORT_CONTROL         = 9'h020;
  localparam logic [8:0] IDX_PORT_STATUS          = 9'h021;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int OPT_PULLUP_BIT   = 7;
  localparam int OPT_EDGE_BIT     = 6;
  localparam int CTL_LVP_BIT      = 0;
  localparam int STS_EXT_BIT      = 0;
  localparam int STS_CHANGE_BIT   = 1;
  localparam int PA_TIMER_PIN     = 4;
  localparam int PB_EXT_PIN       = 0;
  localparam int PB_PGM_PIN       = 3;
  localparam int PB_PCLK_PIN      = 6;
  localparam int PB_PDAT_PIN      = 7;

  // ----------------------------------------
  // Reset values and fixed encodings
  // ----------------------------------------
  localparam logic [7:0] RST_PIN_OPTION  = 8'hff;
  localparam logic [7:0] RST_SECOND_DIR  = 8'hff;
  localparam logic [5:0] RST_FIRST_DIR   = 6'h3f;
  localparam logic [7:0] RST_SECOND_LAT  = 8'h00;
  localparam logic [5:0] RST_FIRST_LAT   = 6'h00;
  localparam logic [3:0] RST_ANALOG_CFG  = 4'h0;
  localparam logic [2:0] RST_COMP_CFG    = 3'h7;
  localparam logic       RST_LVP         = 1'b1;
  localparam logic [2:0] COMP_OFF        = 3'h7;
  localparam logic [3:0] PCFG_DIGITAL_A  = 4'h6;
  localparam logic [3:0] PCFG_DIGITAL_B  = 4'h7;
  localparam logic [3:0] PCFG_ALL_ANALOG = 4'h0;
  localparam logic [5:0] ANALOG_ALL_MASK = 6'h2f;
  localparam logic [5:0] ANALOG_LOW_MASK = 6'h0b;
  localparam logic [5:0] COMP_PIN_MASK   = 6'h0f;
  localparam logic [7:0] CHANGE_PIN_MASK = 8'hf0;

  // ----------------------------------------
  // Option register layout
  // ----------------------------------------
  typedef struct packed {
    logic       pullup_control;
    logic       ext_int_edge_select;
    logic [5:0] timer_fields;
  } dgp_option_t;

endpackage : dgp_pkg

// File: dgp_tb.sv
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------
  // Stimulus, wiring and checks
  // ----------------------------------------
  logic        pclk = 1'b0, presetn = 1'b0, soft_reset = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'h0;
  logic        debug_mode_en = 1'b0, dbg_data_out = 1'b0, dbg_data_oe = 1'b0;
  logic [5:0]  pa_x = 6'h00, pa_xe = 6'h00;
  logic [7:0]  pb_x = 8'h00, pb_xe = 8'h00;
  wire  [31:0] prdata;
  wire         pready, pslverr, timer_clock_input, ext_int_pulse, change_level;
  wire         program_enable, program_clock, program_data;
  wire  [5:0]  pa_in, pa_out, pa_oe;
  wire  [7:0]  pb_in, pb_out, pb_oe, pb_pull_en;
  logic [31:0] rdat;
  logic        rerr;
  int          n_fail = 0, n_tests = 0;

  always #20 pclk = ~pclk;

  dgp_top u_dut (.pclk(pclk), .presetn(presetn), .soft_reset(soft_reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pa_in(pa_in), .pa_out(pa_out),
    .pa_oe(pa_oe), .pb_in(pb_in), .pb_out(pb_out), .pb_oe(pb_oe), .pb_pull_en(pb_pull_en),
    .debug_mode_en(debug_mode_en), .dbg_data_out(dbg_data_out), .dbg_data_oe(dbg_data_oe),
    .timer_clock_input(timer_clock_input), .ext_int_pulse(ext_int_pulse),
    .change_level(change_level), .program_enable(program_enable),
    .program_clock(program_clock), .program_data(program_data));

  dgp_pin_env u_env (.pclk(pclk), .pa_out(pa_out), .pa_oe(pa_oe), .pb_out(pb_out), .pb_oe(pb_oe),
    .pb_pull_en(pb_pull_en), .pa_x(pa_x), .pa_xe(pa_xe), .pb_x(pb_x), .pb_xe(pb_xe),
    .pa_in(pa_in), .pb_in(pb_in));

  task automatic end_sim;
    if (n_fail == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      n_fail++;
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  task automatic apb(input logic w, input logic [8:0] idx, input logic [31:0] wd, input logic [3:0] st);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {1'b0, idx, 2'b00};
    pwdata <= wd;
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
    begin
      n_fail++;
      end_sim();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [8:0] idx, input logic [7:0] v);
    apb(1'b1, idx, {24'h0, v}, 4'h1);
  endtask : wr

  task automatic rdc(input logic [8:0] idx, input logic [31:0] exp, input string what);
    apb(1'b0, idx, 32'h0, 4'h0);
    chk(rdat, exp, what);
  endtask : rdc

  task automatic pulses(input int exp);
    int c;
    c = 0;
    repeat (10)
    begin
      @(posedge pclk);
      if (ext_int_pulse === 1'b1)
        c++;
    end
    chk(32'(c), 32'(exp), "ext_pulses");
  endtask : pulses

  task automatic t_reset;
    pa_x <= 6'h3f;
    pa_xe <= 6'h3f;
    pb_x <= 8'hff;
    pb_xe <= 8'hff;
    cyc(8);
    chk(32'(pa_oe), 32'h0, "pa_oe");
    chk(32'(pb_oe), 32'h0, "pb_oe");
    chk(32'(pb_pull_en), 32'h0, "pull");
    rdc(dgp_pkg::IDX_SECOND_PORT_DIR, 32'hff, "pb_dir");
    rdc(dgp_pkg::IDX_PIN_OPTION_CONFIG, 32'hff, "option");
    rdc(dgp_pkg::IDX_FIRST_PORT_DATA, 32'h10, "pa_analog");
    rdc(dgp_pkg::IDX_COMPARATOR_CONFIG, 32'h7, "comp");
    rdc(dgp_pkg::IDX_PORT_CONTROL, 32'h1, "lvp");
    rdc(dgp_pkg::IDX_SECOND_PORT_DATA, 32'hf7, "pb_lvp");
  endtask : t_reset

  task automatic t_first;
    wr(dgp_pkg::IDX_ANALOG_PIN_CONFIG, 8'h06);
    wr(dgp_pkg::IDX_FIRST_PORT_DATA, 8'h15);
    cyc(2);
    chk(32'(pa_oe), 32'h0, "pa_oe_wr");
    wr(dgp_pkg::IDX_FIRST_PORT_DIR, 8'h00);
    cyc(2);
    chk(32'(pa_oe), 32'h2f, "pa_oe_out");
    chk(32'(pa_out & pa_oe), 32'h05, "pa_out");
    rdc(dgp_pkg::IDX_FIRST_PORT_DIR, 32'h0, "pa_dir");
    cyc(8);
    chk(32'(timer_clock_input), 32'h1, "tmr_hi");
    pa_x <= 6'h2f;
    cyc(8);
    chk(32'(timer_clock_input), 32'h0, "tmr_lo");
    wr(dgp_pkg::IDX_FIRST_PORT_DIR, 8'hff);
    cyc(2);
    chk(32'(pa_oe), 32'h0, "pa_oe_in");
    rdc(dgp_pkg::IDX_FIRST_PORT_DIR, 32'h3f, "pa_dir6");
  endtask : t_first

  task automatic t_rmw;
    pa_x <= 6'h2a;
    cyc(8);
    rdc(dgp_pkg::IDX_FIRST_PORT_DATA, 32'h2a, "pa_pins");
    apb(1'b1, dgp_pkg::IDX_FIRST_PORT_DATA, 32'h0101, 4'h3);
    wr(dgp_pkg::IDX_FIRST_PORT_DIR, 8'h10);
    cyc(2);
    chk(32'(pa_out & pa_oe), 32'h2b, "pa_rmw");
    chk(32'(pa_oe), 32'h2f, "pa_oe_mix");
  endtask : t_rmw

  task automatic t_analog;
    wr(dgp_pkg::IDX_FIRST_PORT_DIR, 8'hff);
    pa_x <= 6'h3f;
    wr(dgp_pkg::IDX_ANALOG_PIN_CONFIG, 8'h00);
    rdc(dgp_pkg::IDX_FIRST_PORT_DATA, 32'h10, "an_all");
    wr(dgp_pkg::IDX_ANALOG_PIN_CONFIG, 8'h01);
    rdc(dgp_pkg::IDX_FIRST_PORT_DATA, 32'h34, "an_low");
    wr(dgp_pkg::IDX_ANALOG_PIN_CONFIG, 8'h07);
    rdc(dgp_pkg::IDX_FIRST_PORT_DATA, 32'h3f, "an_none");
    wr(dgp_pkg::IDX_COMPARATOR_CONFIG, 8'h00);
    rdc(dgp_pkg::IDX_FIRST_PORT_DATA, 32'h30, "comp_on");
    wr(dgp_pkg::IDX_COMPARATOR_CONFIG, 8'h07);
    wr(dgp_pkg::IDX_ANALOG_PIN_CONFIG, 8'h00);
    wr(dgp_pkg::IDX_FIRST_PORT_DIR, 8'h3e);
    cyc(2);
    chk(32'(pa_oe), 32'h01, "an_oe");
  endtask : t_analog

  task automatic t_second;
    wr(dgp_pkg::IDX_PORT_CONTROL, 8'h00);
    wr(dgp_pkg::IDX_PIN_OPTION_CONFIG, 8'h7f);
    cyc(2);
    chk(32'(pb_pull_en), 32'hff, "pull_on");
    wr(dgp_pkg::IDX_SECOND_PORT_DATA, 8'ha5);
    wr(dgp_pkg::IDX_SECOND_PORT_DIR, 8'h00);
    cyc(2);
    chk(32'(pb_oe), 32'hff, "pb_oe_out");
    chk(32'(pb_out), 32'ha5, "pb_out");
    chk(32'(pb_pull_en), 32'h0, "pull_out");
    cyc(6);
    rdc(dgp_pkg::IDX_SECOND_PORT_DATA_ALT, 32'ha5, "pb_alt_rd");
    wr(dgp_pkg::IDX_SECOND_PORT_DATA_ALT, 8'h3c);
    cyc(6);
    rdc(dgp_pkg::IDX_SECOND_PORT_DATA, 32'h3c, "pb_alt_wr");
    soft_reset <= 1'b1;
    cyc(1);
    soft_reset <= 1'b0;
    cyc(2);
    chk(32'(pb_oe), 32'h0, "soft_oe");
    rdc(dgp_pkg::IDX_SECOND_PORT_DIR, 32'hff, "soft_dir");
    rdc(dgp_pkg::IDX_PIN_OPTION_CONFIG, 32'hff, "soft_opt");
    wr(dgp_pkg::IDX_SECOND_PORT_DIR_ALT, 8'h00);
    cyc(2);
    chk(32'(pb_out), 32'h3c, "soft_lat");
  endtask : t_second

  task automatic t_change;
    wr(dgp_pkg::IDX_SECOND_PORT_DIR, 8'hff);
    pb_x <= 8'h00;
    cyc(8);
    rdc(dgp_pkg::IDX_SECOND_PORT_DATA, 32'h0, "snap0");
    wr(dgp_pkg::IDX_PORT_STATUS, 8'h03);
    pb_x <= 8'h04;
    cyc(8);
    chk(32'(change_level), 32'h0, "chg_low");
    pb_x <= 8'h24;
    cyc(8);
    chk(32'(change_level), 32'h1, "chg_hi");
    rdc(dgp_pkg::IDX_PORT_STATUS, 32'h2, "chg_flag");
    rdc(dgp_pkg::IDX_SECOND_PORT_DATA, 32'h24, "snap1");
    cyc(2);
    chk(32'(change_level), 32'h0, "chg_clr");
  endtask : t_change

  task automatic t_extint;
    wr(dgp_pkg::IDX_PIN_OPTION_CONFIG, 8'hff);
    wr(dgp_pkg::IDX_PORT_STATUS, 8'h03);
    pb_x <= 8'h25;
    pulses(1);
    pb_x <= 8'h24;
    pulses(0);
    rdc(dgp_pkg::IDX_PORT_STATUS, 32'h1, "ext_flag");
    wr(dgp_pkg::IDX_PIN_OPTION_CONFIG, 8'hbf);
    pb_x <= 8'h25;
    pulses(0);
    pb_x <= 8'h24;
    pulses(1);
  endtask : t_extint

  task automatic t_prog;
    wr(dgp_pkg::IDX_PORT_CONTROL, 8'h01);
    wr(dgp_pkg::IDX_SECOND_PORT_DIR, 8'h00);
    cyc(2);
    chk(32'(pb_oe), 32'hf7, "lvp_oe");
    pb_x <= 8'h08;
    cyc(8);
    chk(32'(program_enable), 32'h1, "prog_en");
    wr(dgp_pkg::IDX_SECOND_PORT_DIR, 8'hff);
    pb_x <= 8'h40;
    debug_mode_en <= 1'b1;
    dbg_data_oe <= 1'b1;
    dbg_data_out <= 1'b1;
    cyc(8);
    chk(32'(program_clock), 32'h1, "prog_clk");
    chk(32'(pb_oe[7] & pb_out[7]), 32'h1, "dbg_drive");
    chk(32'(program_data), 32'h1, "prog_dat");
    apb(1'b0, 9'h1ff, 32'h0, 4'h0);
    chk(32'(rerr), 32'h1, "unmapped");
  endtask : t_prog

  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_first();
    t_rmw();
    t_analog();
    t_second();
    t_change();
    t_extint();
    t_prog();
    end_sim();
  end
endmodule : testbench

// File: dgp_top.sv
`timescale 1ns/1ps
// Function
// - Direction one makes first-port pin input
// - Direction zero drives latch onto first-port pin
// - Reads return pins, writes go to latch
// - Writes merge sampled pins with written bits
// - First port has six data/direction bits
// - Timer pin: filtered input, open-drain output
// - Analog/comparator config selects pin function
// - Power-on: analog pins read zero, comparators off
// - Direction bits still drive analog pins
// - Enabled program or debug mode takes over its pins
// - Second-port weak pull-ups from option bit 7
// - Second-port bit 0 is external interrupt
// - Bits four to seven flag level changes
// - Program mode on by default, takes bit 3
// - Bits six, seven serve debug clock/data
// - Second-port latch kept over other resets
// - Second-port direction resets to all ones
// - Second-port data seen at two addresses
module dgp_top #(
  parameter int PA_W = 6,
  parameter int PB_W = 8
) (
  // Clock and reset
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            soft_reset,
  // APB slave
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [11:0]     paddr,
  input  wire logic [31:0]     pwdata,
  input  wire logic [3:0]      pstrb,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  // First port pins
  input  wire logic [PA_W-1:0] pa_in,
  output logic      [PA_W-1:0] pa_out,
  output logic      [PA_W-1:0] pa_oe,
  // Second port pins
  input  wire logic [PB_W-1:0] pb_in,
  output logic      [PB_W-1:0] pb_out,
  output logic      [PB_W-1:0] pb_oe,
  output logic      [PB_W-1:0] pb_pull_en,
  // Shared peripheral functions
  input  wire logic            debug_mode_en,
  input  wire logic            dbg_data_out,
  input  wire logic            dbg_data_oe,
  output logic                 timer_clock_input,
  output logic                 ext_int_pulse,
  output logic                 change_level,
  output logic                 program_enable,
  output logic                 program_clock,
  output logic                 program_data
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [5:0] analog_mask(input logic [3:0] pcfg, input logic [2:0] cm);
    logic [5:0] m;
    m = 6'h00;
    if (pcfg == dgp_pkg::PCFG_ALL_ANALOG)
      m = dgp_pkg::ANALOG_ALL_MASK;
    else if (pcfg != dgp_pkg::PCFG_DIGITAL_A && pcfg != dgp_pkg::PCFG_DIGITAL_B)
      m = dgp_pkg::ANALOG_LOW_MASK;
    if (cm != dgp_pkg::COMP_OFF)
      m = m | dgp_pkg::COMP_PIN_MASK;
    return m;
  endfunction : analog_mask

  function automatic logic [7:0] settle(input logic [7:0] s2, input logic [7:0] s3, input logic [7:0] lv);
    return (~(s2 ^ s3) & s3) | ((s2 ^ s3) & lv);
  endfunction : settle

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [PA_W-1:0]      pa_s1_q, pa_s2_q, pa_s3_q, pa_lv_q;
  logic [PB_W-1:0]      pb_s1_q, pb_s2_q, pb_s3_q, pb_lv_q;
  logic [PA_W-1:0]      pa_lat_q, pa_dir_q;
  logic [PB_W-1:0]      pb_lat_q, pb_dir_q, pb_snap_q;
  dgp_pkg::dgp_option_t opt_q;
  logic [3:0]           pcfg_q;
  logic [2:0]           cm_q;
  logic                 lvp_q;
  logic                 ext_flag_q, chg_flag_q, ext_prev_q;
  logic [8:0]           idx;
  logic                 acc, wr_en, rd_en, hit;
  logic [31:0]          rd_data;
  logic [5:0]           amask;
  logic [7:0]           wmask, pb_merge, pb_rd, pb_mis;
  logic [5:0]           pa_merge, pa_rd;
  logic                 ext_edge;
  logic [7:0]           pa_settled;

  assign idx   = paddr[10:2];
  assign acc   = psel & penable & pready;
  assign wr_en = acc & pwrite & pstrb[0];
  assign rd_en = acc & ~pwrite;
  assign amask = analog_mask(pcfg_q, cm_q);
  assign wmask = pstrb[1] ? pwdata[15:8] : 8'hff;
  assign pa_settled = settle({2'b00, pa_s2_q}, {2'b00, pa_s3_q}, {2'b00, pa_lv_q});

  // ----------------------------------------
  // Pin input synchronisers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pa_s1_q <= '0;
      pa_s2_q <= '0;
      pa_s3_q <= '0;
      pa_lv_q <= '0;
      pb_s1_q <= '0;
      pb_s2_q <= '0;
      pb_s3_q <= '0;
      pb_lv_q <= '0;
    end
    else
    begin
      pa_s1_q <= pa_in;
      pa_s2_q <= pa_s1_q;
      pa_s3_q <= pa_s2_q;
      pa_lv_q <= pa_settled[5:0];
      pb_s1_q <= pb_in;
      pb_s2_q <= pb_s1_q;
      pb_s3_q <= pb_s2_q;
      pb_lv_q <= settle(pb_s2_q, pb_s3_q, pb_lv_q);
    end
  end

  // ----------------------------------------
  // Read values and write merge
  // ----------------------------------------
  always_comb
  begin
    pa_rd    = pa_lv_q & ~amask;
    pb_rd    = pb_lv_q;
    if (lvp_q)
      pb_rd[dgp_pkg::PB_PGM_PIN] = 1'b0;
    pa_merge = (pa_rd & ~wmask[5:0]) | (pwdata[5:0] & wmask[5:0]);
    pb_merge = (pb_rd & ~wmask) | (pwdata[7:0] & wmask);
  end

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  always_comb
  begin
    rd_data = 32'h0000_0000;
    hit     = 1'b1;
    if (idx == dgp_pkg::IDX_SECOND_PORT_DATA || idx == dgp_pkg::IDX_SECOND_PORT_DATA_ALT)
      rd_data[7:0] = pb_rd;
    else if (idx == dgp_pkg::IDX_PIN_OPTION_CONFIG || idx == dgp_pkg::IDX_PIN_OPTION_ALT)
      rd_data[7:0] = opt_q;
    else if (idx == dgp_pkg::IDX_SECOND_PORT_DIR || idx == dgp_pkg::IDX_SECOND_PORT_DIR_ALT)
      rd_data[7:0] = pb_dir_q;
    else if (idx == dgp_pkg::IDX_FIRST_PORT_DATA)
      rd_data[5:0] = pa_rd;
    else if (idx == dgp_pkg::IDX_FIRST_PORT_DIR)
      rd_data[5:0] = pa_dir_q;
    else if (idx == dgp_pkg::IDX_ANALOG_PIN_CONFIG)
      rd_data[3:0] = pcfg_q;
    else if (idx == dgp_pkg::IDX_COMPARATOR_CONFIG)
      rd_data[2:0] = cm_q;
    else if (idx == dgp_pkg::IDX_PORT_CONTROL)
      rd_data[dgp_pkg::CTL_LVP_BIT] = lvp_q;
    else if (idx == dgp_pkg::IDX_PORT_STATUS)
      rd_data[1:0] = {chg_flag_q, ext_flag_q};
    else
      hit = 1'b0;
  end

  // No wait state: answer is prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit;
      prdata  <= (psel & ~penable & ~pwrite) ? rd_data : 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // First port registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pa_lat_q <= dgp_pkg::RST_FIRST_LAT;
      pa_dir_q <= dgp_pkg::RST_FIRST_DIR;
      pcfg_q   <= dgp_pkg::RST_ANALOG_CFG;
      cm_q     <= dgp_pkg::RST_COMP_CFG;
    end
    else if (soft_reset)
    begin
      pa_dir_q <= dgp_pkg::RST_FIRST_DIR;
    end
    else if (wr_en)
    begin
      if (idx == dgp_pkg::IDX_FIRST_PORT_DATA)
        pa_lat_q <= pa_merge;
      else if (idx == dgp_pkg::IDX_FIRST_PORT_DIR)
        pa_dir_q <= pwdata[5:0];
      else if (idx == dgp_pkg::IDX_ANALOG_PIN_CONFIG)
        pcfg_q <= pwdata[3:0];
      else if (idx == dgp_pkg::IDX_COMPARATOR_CONFIG)
        cm_q <= pwdata[2:0];
    end
  end

  // ----------------------------------------
  // Second port registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pb_lat_q <= dgp_pkg::RST_SECOND_LAT;
      pb_dir_q <= dgp_pkg::RST_SECOND_DIR;
      opt_q    <= dgp_pkg::RST_PIN_OPTION;
      lvp_q    <= dgp_pkg::RST_LVP;
    end
    else if (soft_reset)
    begin
      pb_dir_q <= dgp_pkg::RST_SECOND_DIR;
      opt_q    <= dgp_pkg::RST_PIN_OPTION;
    end
    else if (wr_en)
    begin
      if (idx == dgp_pkg::IDX_SECOND_PORT_DATA || idx == dgp_pkg::IDX_SECOND_PORT_DATA_ALT)
        pb_lat_q <= pb_merge;
      else if (idx == dgp_pkg::IDX_SECOND_PORT_DIR || idx == dgp_pkg::IDX_SECOND_PORT_DIR_ALT)
        pb_dir_q <= pwdata[7:0];
      else if (idx == dgp_pkg::IDX_PIN_OPTION_CONFIG || idx == dgp_pkg::IDX_PIN_OPTION_ALT)
        opt_q <= pwdata[7:0];
      else if (idx == dgp_pkg::IDX_PORT_CONTROL)
        lvp_q <= pwdata[dgp_pkg::CTL_LVP_BIT];
    end
  end

  // ----------------------------------------
  // Change detect and external interrupt
  // ----------------------------------------
  assign pb_mis   = (pb_lv_q ^ pb_snap_q) & pb_dir_q & dgp_pkg::CHANGE_PIN_MASK;
  assign ext_edge = opt_q.ext_int_edge_select ? (pb_lv_q[dgp_pkg::PB_EXT_PIN] & ~ext_prev_q)
                                              : (~pb_lv_q[dgp_pkg::PB_EXT_PIN] & ext_prev_q);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pb_snap_q  <= '0;
      ext_prev_q <= 1'b0;
      ext_flag_q <= 1'b0;
      chg_flag_q <= 1'b0;
    end
    else
    begin
      if (rd_en && (idx == dgp_pkg::IDX_SECOND_PORT_DATA || idx == dgp_pkg::IDX_SECOND_PORT_DATA_ALT))
        pb_snap_q <= pb_lv_q;
      ext_prev_q <= pb_lv_q[dgp_pkg::PB_EXT_PIN];
      // Set wins over a simultaneous write-one clear
      if (ext_edge && pb_dir_q[dgp_pkg::PB_EXT_PIN])
        ext_flag_q <= 1'b1;
      else if (wr_en && idx == dgp_pkg::IDX_PORT_STATUS && pwdata[dgp_pkg::STS_EXT_BIT])
        ext_flag_q <= 1'b0;
      if (|pb_mis)
        chg_flag_q <= 1'b1;
      else if (wr_en && idx == dgp_pkg::IDX_PORT_STATUS && pwdata[dgp_pkg::STS_CHANGE_BIT])
        chg_flag_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Pin drive and peripheral outputs
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pa_out            <= '0;
      pa_oe             <= '0;
      pb_out            <= '0;
      pb_oe             <= '0;
      pb_pull_en        <= '0;
      timer_clock_input <= 1'b0;
      ext_int_pulse     <= 1'b0;
      change_level      <= 1'b0;
      program_enable    <= 1'b0;
      program_clock     <= 1'b0;
      program_data      <= 1'b0;
    end
    else
    begin
      pa_out                       <= pa_lat_q;
      pa_out[dgp_pkg::PA_TIMER_PIN] <= 1'b0;
      pa_oe                        <= ~pa_dir_q;
      pa_oe[dgp_pkg::PA_TIMER_PIN]  <= ~pa_dir_q[dgp_pkg::PA_TIMER_PIN] & ~pa_lat_q[dgp_pkg::PA_TIMER_PIN];
      pb_out <= pb_lat_q;
      pb_oe  <= ~pb_dir_q;
      if (lvp_q)
        pb_oe[dgp_pkg::PB_PGM_PIN] <= 1'b0;
      if (debug_mode_en)
      begin
        pb_oe[dgp_pkg::PB_PCLK_PIN]  <= 1'b0;
        pb_oe[dgp_pkg::PB_PDAT_PIN]  <= dbg_data_oe;
        pb_out[dgp_pkg::PB_PDAT_PIN] <= dbg_data_out;
      end
      pb_pull_en        <= {PB_W{~opt_q.pullup_control}} & pb_dir_q;
      timer_clock_input <= pa_lv_q[dgp_pkg::PA_TIMER_PIN];
      ext_int_pulse     <= ext_edge & pb_dir_q[dgp_pkg::PB_EXT_PIN];
      change_level      <= |pb_mis;
      program_enable    <= lvp_q & pb_lv_q[dgp_pkg::PB_PGM_PIN];
      program_clock     <= debug_mode_en & pb_lv_q[dgp_pkg::PB_PCLK_PIN];
      program_data      <= debug_mode_en & pb_lv_q[dgp_pkg::PB_PDAT_PIN];
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_PA_INPUT_HIZ: assert property ($past(presetn) |-> (pa_oe & $past(pa_dir_q)) == '0)
    else $error("first port input pin driven");
  AST_PA_OUTPUT_DRIVE: assert property (pa_dir_q[0] == 1'b0 ##1 1'b1 |-> pa_oe[0] && pa_out[0] == $past(pa_lat_q[0]))
    else $error("first port output not driving latch");
  AST_PB_WRITE_MERGE: assert property (wr_en && idx == dgp_pkg::IDX_SECOND_PORT_DATA_ALT && !soft_reset
    |=> pb_lat_q == $past(pb_merge))
    else $error("second port write merge wrong");
  AST_TIMER_OPEN_DRAIN: assert property (!(pa_oe[dgp_pkg::PA_TIMER_PIN] && pa_out[dgp_pkg::PA_TIMER_PIN]))
    else $error("timer pin driven high");
  AST_ANALOG_READ_ZERO: assert property (psel && !penable && !pwrite && idx == dgp_pkg::IDX_FIRST_PORT_DATA
    |=> (prdata[5:0] & $past(amask)) == '0)
    else $error("analog pin read not zero");
  AST_PB_DIR_RESET: assert property (soft_reset |=> pb_dir_q == dgp_pkg::RST_SECOND_DIR ##1 pb_oe == '0)
    else $error("second port direction not reset");
  AST_PB_LATCH_KEPT: assert property (soft_reset |=> $stable(pb_lat_q))
    else $error("second port latch lost on reset");
  AST_PULLUP: assert property ($past(presetn) && $past(!opt_q.pullup_control) |-> pb_pull_en == $past(pb_dir_q))
    else $error("pull-up enable mismatch");
  AST_PGM_PIN_TAKEN: assert property (lvp_q |=> !pb_oe[dgp_pkg::PB_PGM_PIN])
    else $error("program pin still driven");
  AST_CHANGE_FLAG: assert property (|pb_mis |=> change_level && chg_flag_q)
    else $error("change not flagged");

endmodule : dgp_top
